/* File: brrm_map.svh */
// Purpose: offsets, field positions and counts of the link message framer
// Assumes: byte-wide frames, payload index counted from zero
// Notes: offsets and type codes live here as macros; the data3 length and the one-byte reply lengths are literals in the framer
`ifndef BRRM_MAP_SVH
`define BRRM_MAP_SVH
`define BRRM_FCNT_FIRST 8'h00
`define BRRM_FCNT_LAST 8'h03
`define BRRM_DATA3_FIRST 8'h16
`define BRRM_DATA5_LAST 8'h27
`define BRRM_REQ_LAST 8'h30
`define BRRM_CODE_BYTES 8'h04
`define BRRM_KEY_BIT 7
`define BRRM_ENR_LAST 8'h03
`define BRRM_HDR_BYTES 8'h02
`define BRRM_T_REQ 8'h01
`define BRRM_T_ENR 8'h02
`define BRRM_T_RSP 8'h81
`define BRRM_T_FAIL 8'h82
`define BRRM_T_DONE 8'h83
`define BRRM_L1_HDR 8'ha5
`endif

/* File: brrm_pkg.sv */
// Purpose: types shared by the framer files
// Assumes: nothing beyond the map header
// Notes: byte stream struct carries data with frame delimiters
package brrm_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic first;
        logic last;
    } brrm_byte_t;
    typedef struct packed {
        logic ok;
        logic key_b;
        logic [31:0] code;
        logic [7:0] fail_code;
    } brrm_result_t;
endpackage

/* File: brrm_tx.sv */
// Purpose: serialiser for outgoing frames, headers then payload
// Assumes: caller holds the payload stable while busy
// Notes: one byte per accepted ready cycle
`timescale 1ns/1ps
`include "brrm_map.svh"
module brrm_tx (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [7:0] i_type,
    input wire logic [7:0] i_len,
    input wire logic [39:0] i_payload,
    input wire logic i_ready,
    output brrm_pkg::brrm_byte_t o_byte,
    output logic o_valid,
    output logic o_busy
);
    import brrm_pkg::*;
    logic [7:0] idx;
    logic [7:0] next_idx;
    logic busy;
    logic next_busy;
    logic [7:0] total;
    logic [7:0] cur;
    // Byte pick: layer one then type header, ascending
    always_comb begin
        total = i_len + `BRRM_HDR_BYTES;
        if (idx == 8'h00)
            cur = `BRRM_L1_HDR;
        else if (idx == 8'h01)
            cur = i_type;
        else
            cur = i_payload[8'(39 - 8 * (idx - 8'h02)) -: 8];
        next_idx = idx;
        next_busy = busy;
        if (!busy && i_start) begin
            next_busy = 1'b1;
            next_idx = 8'h00;
        end else if (busy && i_ready) begin
            next_idx = idx + 8'h01;
            if (idx == total - 8'h01)
                next_busy = 1'b0;
        end
    end
    // State registers
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            idx <= 8'h00;
            busy <= 1'b0;
        end else begin
            idx <= next_idx;
            busy <= next_busy;
        end
    end
    assign o_valid = busy;
    assign o_busy = busy;
    assign o_byte.data = busy ? cur : 8'h00;
    assign o_byte.first = busy && idx == 8'h00;
    assign o_byte.last = busy && idx == total - 8'h01;
endmodule // brrm_tx

/* File: brrm_framer.sv */
// Purpose: frame parser and reply builder of the security module link
// Assumes: incoming bytes come from same-clock logic, one per valid cycle
// Notes: integrity computation is outside; result arrives on i_result
`timescale 1ns/1ps
`include "brrm_map.svh"
module brrm_framer (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input brrm_pkg::brrm_byte_t i_rx,
    input wire logic i_rx_valid,
    input wire logic i_result_valid,
    input brrm_pkg::brrm_result_t i_result,
    input wire logic i_enr_done,
    input wire logic i_enr_new,
    input wire logic i_tx_ready,
    output logic o_rx_ready,
    output logic [31:0] o_frame_count,
    output logic [47:0] o_req_data3,
    output logic o_req_valid,
    output logic [15:0] o_challenge_reply_timeout,
    output logic [15:0] o_enrollment_request_timeout,
    output logic o_enr_start,
    output brrm_pkg::brrm_byte_t o_tx,
    output logic o_tx_valid
);
    import brrm_pkg::*;
    typedef enum logic [3:0] {
        S_HDR = 4'b0001,
        S_TYPE = 4'b0010,
        S_PAY = 4'b0100,
        S_WAIT = 4'b1000
    } brrm_state_t;
    brrm_state_t st, next_st;
    logic [7:0] ftype, next_ftype;
    logic [7:0] pos, next_pos;
    logic [31:0] fcnt, next_fcnt;
    logic [47:0] d3, next_d3;
    logic [31:0] tmo, next_tmo;
    logic [31:0] tout, next_tout;
    logic req_v, next_req_v;
    logic enr_v, next_enr_v;
    logic start, next_start;
    logic [7:0] ttype, next_ttype;
    logic [7:0] tlen, next_tlen;
    logic [39:0] tpay, next_tpay;
    logic tx_busy;
    logic rx_take;
    assign o_rx_ready = (st != S_WAIT);
    assign rx_take = i_rx_valid && o_rx_ready;
    // Parser and reply builder
    always_comb begin
        next_st = st;
        next_ftype = ftype;
        next_pos = pos;
        next_fcnt = fcnt;
        next_d3 = d3;
        next_tmo = tmo;
        next_tout = tout;
        next_req_v = 1'b0;
        next_enr_v = 1'b0;
        next_start = 1'b0;
        next_ttype = ttype;
        next_tlen = tlen;
        next_tpay = tpay;
        case (st)
            S_HDR: begin
                if (rx_take && i_rx.first && i_rx.data == `BRRM_L1_HDR)
                    next_st = S_TYPE;
            end
            S_TYPE: begin
                if (rx_take) begin
                    next_ftype = i_rx.data;
                    next_pos = 8'h00;
                    next_st = S_PAY;
                end
            end
            S_PAY: begin
                if (rx_take) begin
                    if (ftype == `BRRM_T_REQ && pos <= `BRRM_FCNT_LAST)
                        next_fcnt = {fcnt[23:0], i_rx.data};
                    if (ftype == `BRRM_T_REQ && pos >= `BRRM_DATA3_FIRST &&
                        pos < `BRRM_DATA3_FIRST + 8'h06)
                        next_d3 = {d3[39:0], i_rx.data};
                    if (ftype == `BRRM_T_ENR && pos <= `BRRM_ENR_LAST)
                        next_tmo = {tmo[23:0], i_rx.data};
                    next_pos = pos + 8'h01;
                    if (i_rx.last) begin
                        next_st = S_HDR;
                        // request ends at spare byte 48
                        if (ftype == `BRRM_T_REQ && pos == `BRRM_REQ_LAST) begin
                            next_req_v = 1'b1;
                            next_st = S_WAIT;
                        end
                        if (ftype == `BRRM_T_ENR && pos == `BRRM_ENR_LAST)
                        begin
                            // A cut enrolment frame never reaches the timeout outputs
                            next_enr_v = 1'b1;
                            next_tout = {tmo[23:0], i_rx.data};
                        end
                    end
                end
            end
            S_WAIT: begin
                if (i_result_valid && !tx_busy) begin
                    next_start = 1'b1;
                    next_st = S_HDR;
                    if (i_result.ok) begin
                        next_ttype = `BRRM_T_RSP;
                        next_tlen = `BRRM_CODE_BYTES + 8'h01;
                        next_tpay = {i_result.code, i_result.key_b, 7'h00};
                    end else begin
                        next_ttype = `BRRM_T_FAIL;
                        next_tlen = 8'h01;
                        next_tpay = {i_result.fail_code, 32'h0};
                    end
                end
            end
            default: next_st = S_HDR;
        endcase
        if (st != S_WAIT && i_enr_done && !tx_busy && !start) begin
            next_start = 1'b1;
            next_ttype = `BRRM_T_DONE;
            next_tlen = 8'h01;
            next_tpay = {i_enr_new, 39'h0};
        end
    end
    // Registers
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            st <= S_HDR;
            ftype <= 8'h00;
            pos <= 8'h00;
            fcnt <= 32'h0;
            d3 <= 48'h0;
            tmo <= 32'h0;
            tout <= 32'h0;
            req_v <= 1'b0;
            enr_v <= 1'b0;
            start <= 1'b0;
            ttype <= 8'h00;
            tlen <= 8'h00;
            tpay <= 40'h0;
        end else begin
            st <= next_st;
            ftype <= next_ftype;
            pos <= next_pos;
            fcnt <= next_fcnt;
            d3 <= next_d3;
            tmo <= next_tmo;
            tout <= next_tout;
            req_v <= next_req_v;
            enr_v <= next_enr_v;
            start <= next_start;
            ttype <= next_ttype;
            tlen <= next_tlen;
            tpay <= next_tpay;
        end
    end
    assign o_frame_count = fcnt;
    assign o_req_data3 = d3;
    assign o_req_valid = req_v;
    assign o_challenge_reply_timeout = tout[31:16];
    assign o_enrollment_request_timeout = tout[15:0];
    assign o_enr_start = enr_v;
    // Serialiser
    brrm_tx u_tx (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_start(start),
        .i_type(ttype),
        .i_len(tlen),
        .i_payload(tpay),
        .i_ready(i_tx_ready),
        .o_byte(o_tx),
        .o_valid(o_tx_valid),
        .o_busy(tx_busy)
    );
    property p_fcnt;
        @(posedge i_sys_clk) disable iff (i_rst)
        (st == S_PAY && rx_take && ftype == `BRRM_T_REQ && pos == 8'h03)
        |=> fcnt[7:0] == $past(i_rx.data);
    endproperty
    a_fcnt: assert property (p_fcnt) else $error("frame count");
    property p_req;
        @(posedge i_sys_clk) disable iff (i_rst)
        o_req_valid |-> $past(pos) == `BRRM_REQ_LAST;
    endproperty
    a_req: assert property (p_req) else $error("request length");
    sequence s_ok;
        st == S_WAIT && i_result_valid && !tx_busy && i_result.ok;
    endsequence
    property p_rsp;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_ok |=> ttype == `BRRM_T_RSP && tlen == 8'h05;
    endproperty
    a_rsp: assert property (p_rsp) else $error("response");
    property p_key;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_ok |=> tpay[7] == $past(i_result.key_b);
    endproperty
    a_key: assert property (p_key) else $error("key bit");
    property p_fail;
        @(posedge i_sys_clk) disable iff (i_rst)
        (st == S_WAIT && i_result_valid && !tx_busy && !i_result.ok)
        |=> ttype == `BRRM_T_FAIL && tpay[39:32] == $past(i_result.fail_code);
    endproperty
    a_fail: assert property (p_fail) else $error("failure");
    property p_tmo;
        @(posedge i_sys_clk) disable iff (i_rst)
        o_enr_start |-> o_enrollment_request_timeout[7:0] == $past(i_rx.data);
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout");
    property p_tkeep;
        @(posedge i_sys_clk) disable iff (i_rst)
        !o_enr_start |->
            $stable({o_challenge_reply_timeout, o_enrollment_request_timeout});
    endproperty
    a_tkeep: assert property (p_tkeep) else $error("timeout held");
    property p_done;
        @(posedge i_sys_clk) disable iff (i_rst)
        (st != S_WAIT && i_enr_done && !tx_busy && !start)
        |=> ttype == `BRRM_T_DONE && tpay[39] == $past(i_enr_new);
    endproperty
    a_done: assert property (p_done) else $error("complete");
    property p_hdr;
        @(posedge i_sys_clk) disable iff (i_rst)
        (o_tx_valid && o_tx.first) |-> o_tx.data == `BRRM_L1_HDR;
    endproperty
    a_hdr: assert property (p_hdr) else $error("header");
endmodule // brrm_framer

/* File: brrm_term_model.sv */
// Purpose: terminal side model, sends frames and sinks replies
// Assumes: framer inputs change at the falling edge
// Notes: ready may stall every other cycle to stress the sender
`timescale 1ns/1ps
module brrm_term_model (
    input wire logic i_sys_clk,
    input wire logic i_rx_ready,
    input brrm_pkg::brrm_byte_t i_tx,
    input wire logic i_tx_valid,
    output brrm_pkg::brrm_byte_t o_rx,
    output logic o_rx_valid,
    output logic o_tx_ready
);
    import brrm_pkg::*;
    logic [7:0] pay [0:48];
    brrm_byte_t rxq [$];
    logic slow = 1'b0;
    logic [39:0] kept = 40'h0;
    logic [7:0] ftype = 8'h0;
    int pos = 0;
    initial begin
        o_rx = '0;
        o_rx_valid = 1'b0;
        o_tx_ready = 1'b1;
    end
    task automatic send(input logic [7:0] typ, input int n);
        for (int i = -2; i < n; i++) begin
            @(negedge i_sys_clk);
            o_rx.data = (i == -2) ? 8'ha5 : (i == -1) ? typ : pay[i];
            o_rx.first = (i == -2);
            o_rx.last = (i == n - 1);
            o_rx_valid = 1'b1;
            #1;
            while (!i_rx_ready) begin
                @(negedge i_sys_clk);
                #1;
            end
        end
        @(negedge i_sys_clk);
        // Released line shows the inverse, never the stale byte
        o_rx_valid = 1'b0;
        o_rx.data = ~o_rx.data;
    endtask
    // Ready set first, so the byte seen here is taken next rise
    always @(negedge i_sys_clk) begin
        o_tx_ready = slow ? ~o_tx_ready : 1'b1;
        if (i_tx_valid && o_tx_ready) begin
            rxq.push_back(i_tx);
            pos = i_tx.first ? 0 : pos + 1;
            if (pos == 1) ftype = i_tx.data;
            // code and key kept for the bench to compare
            if (pos > 1 && ftype == 8'h81) kept = {kept[31:0], i_tx.data};
        end
    end
endmodule // brrm_term_model

/* File: tb_bw_request_registration_msgs.sv */
// Purpose: self-checking bench of the security module framer
// Assumes: integrity result is supplied by the bench
// Notes: one task per scenario, partner model drives the link
`timescale 1ns/1ps
module tb_bw_request_registration_msgs;
    import brrm_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_result_valid = 1'b0;
    brrm_result_t i_result = '0;
    logic i_enr_done = 1'b0;
    logic i_enr_new = 1'b0;
    brrm_byte_t rx, tx;
    logic rx_valid, rx_ready, tx_valid, tx_ready, req_valid, enr_start;
    logic [31:0] fcount;
    logic [47:0] data3;
    logic [15:0] reply_to, enr_to;
    logic [7:0] exp [0:7];
    int err_total = 0;
    int checked = 0;
    int cycles = 0;
    brrm_framer dut_u (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_rx(rx),
        .i_rx_valid(rx_valid), .i_result_valid(i_result_valid),
        .i_result(i_result), .i_enr_done(i_enr_done),
        .i_enr_new(i_enr_new), .i_tx_ready(tx_ready),
        .o_rx_ready(rx_ready), .o_frame_count(fcount),
        .o_req_data3(data3), .o_req_valid(req_valid),
        .o_challenge_reply_timeout(reply_to),
        .o_enrollment_request_timeout(enr_to),
        .o_enr_start(enr_start), .o_tx(tx), .o_tx_valid(tx_valid));
    brrm_term_model term_u (
        .i_sys_clk(i_sys_clk), .i_rx_ready(rx_ready), .i_tx(tx),
        .i_tx_valid(tx_valid), .o_rx(rx), .o_rx_valid(rx_valid),
        .o_tx_ready(tx_ready));
    // Clock and hang guard
    initial forever #12.5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [47:0] e,
                       input logic [47:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One-cycle pulse expected within a few cycles
    task automatic wait_hi(ref logic s, input string nm);
        for (int w = 0; w < 8 && s !== 1'b1; w++) @(negedge i_sys_clk);
        chk(nm, 48'h1, {47'h0, s});
        @(negedge i_sys_clk);
        chk(nm, 48'h0, {47'h0, s});
    endtask
    // Whole reply: bytes, delimiters, nothing extra
    task automatic chk_frame(input int n, input logic [7:0] lmask);
        brrm_byte_t b;
        logic [7:0] m;
        for (int w = 0; w < 400 && term_u.rxq.size() < n; w++)
            @(negedge i_sys_clk);
        chk("reply size", 48'(n), 48'(term_u.rxq.size()));
        for (int i = 0; i < n && term_u.rxq.size() > 0; i++) begin
            b = term_u.rxq.pop_front();
            m = (i == n - 1) ? lmask : 8'hff;
            chk("reply byte", {40'h0, exp[i] & m}, {40'h0, b.data & m});
            chk("delims", {46'h0, i == 0, i == n - 1}, {46'h0, b.first, b.last});
        end
    endtask
    task automatic req_frame();
        for (int i = 0; i < 49; i++) term_u.pay[i] = 8'(i + 1);
        term_u.send(8'h01, 49);
        wait_hi(req_valid, "request pulse");
        chk("frame count", 48'h01020304, {16'h0, fcount});
        chk("request data 3", 48'h1718191a1b1c, data3);
    endtask
    task automatic give(input brrm_result_t r);
        i_result = r;
        i_result_valid = 1'b1;
        @(negedge i_sys_clk);
        i_result_valid = 1'b0;
    endtask
    task automatic t_code(input logic key_b, input logic slow);
        term_u.slow = slow;
        req_frame();
        give({1'b1, key_b, 32'hc0de5a11, 8'h00});
        exp = '{8'ha5, 8'h81, 8'hc0, 8'hde, 8'h5a, 8'h11, {key_b, 7'h0}, 8'h0};
        chk_frame(7, 8'h80);
        chk("kept", {15'h0, 32'hc0de5a11, key_b},
            {15'h0, term_u.kept[39:8], term_u.kept[7]});
    endtask
    task automatic t_fail();
        req_frame();
        give({1'b0, 1'b0, 32'h0, 8'h3c});
        exp = '{8'ha5, 8'h82, 8'h3c, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
        chk_frame(3, 8'hff);
    endtask
    task automatic t_enrol(input logic [31:0] v);
        {term_u.pay[0], term_u.pay[1], term_u.pay[2], term_u.pay[3]} = v;
        term_u.send(8'h02, 4);
        wait_hi(enr_start, "enrolment start");
        chk("reply timeout", {32'h0, v[31:16]}, {32'h0, reply_to});
        chk("request timeout", {32'h0, v[15:0]}, {32'h0, enr_to});
    endtask
    // Short enrolment frame must leave both timeouts alone
    task automatic t_drop();
        term_u.send(8'h02, 3);
        repeat (4) @(negedge i_sys_clk);
        chk("timeouts kept", 48'h00fffe01, {16'h0, reply_to, enr_to});
    endtask
    task automatic t_done(input logic fresh);
        i_enr_new = fresh;
        i_enr_done = 1'b1;
        @(negedge i_sys_clk);
        // Held until the sender starts, a busy sender ignores it
        for (int w = 0; w < 8 && tx_valid !== 1'b1; w++)
            @(negedge i_sys_clk);
        i_enr_done = 1'b0;
        exp[0:2] = '{8'ha5, 8'h83, {fresh, 7'h0}};
        chk_frame(3, 8'h80);
    endtask
    task automatic final_report();
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge i_sys_clk);
        i_rst = 1'b0;
        chk("count at reset", 48'h0, {16'h0, fcount});
        t_code(1'b1, 1'b0);
        t_code(1'b0, 1'b1);
        t_fail();
        t_enrol(32'habcd1234);
        t_enrol(32'h00fffe01);
        t_drop();
        t_done(1'b1);
        t_done(1'b0);
        final_report();
    end
endmodule // tb_bw_request_registration_msgs
